// >>> src/ascr_regs.svh
// constants of the angle sensor command register set
`ifndef ASCR_REGS_SVH
`define ASCR_REGS_SVH
// ==========================================================
// command byte layout
`define ASCR_REGION_NVM  3'h0
`define ASCR_REGION_CMD  3'h4
`define ASCR_ADDR_CTRL   4'h1
`define ASCR_ADDR_KEY    4'ha
`define ASCR_ADDR_TEST   4'hb
`define ASCR_CUST_FIRST  4'h8
`define ASCR_KEY_VALUE   16'h16f4
// ==========================================================
// control_status and test_control fields
`define ASCR_BIT_DIAG    15
`define ASCR_BIT_SUPP    14
`define ASCR_BIT_UV      12
`define ASCR_BIT_PUMP    11
`define ASCR_BIT_CORR    8
`define ASCR_BIT_UNCORR  7
`define ASCR_BIT_FLOSS   6
`define ASCR_BIT_CRC     4
`define ASCR_BIT_WREN    11
`define ASCR_CTRL_RST    16'h0000
`define ASCR_TEST_RST    16'h0000
// ==========================================================
// timing
`define ASCR_CLK_MHZ     25
`define ASCR_TCMD_ENT_US 30000
`define ASCR_TPROG_US    20
`endif

// >>> src/ascr_pkg.sv
// types of the angle sensor command register set
package ascr_pkg;
  typedef enum logic [2:0] {
    ASCR_WAIT_KEY = 3'b001,
    ASCR_NORMAL   = 3'b010,
    ASCR_COMMAND  = 3'b100
  } ascr_mode_t;
endpackage : ascr_pkg

// >>> src/ascr_cmd_regs.sv
// command-mode control and status registers of one sensor channel
// Behaviour
// - key 16f4h after reset, within window, enters
// - bit 15 shows diagnostic condition, unmasked
// - bit 14 write-only, forces diagnostics off
// - bit 12 shows undervoltage
// - bit 11 pump clock enable, after write enable; the device takes it without checking write enable
// - bit 8 sticky corrected memory error
// - bit 7 sticky uncorrectable memory error
// - bit 6 sticky field loss, gated to diagnostics
// - bit 4 checksum mismatch, taken each start-up
// - test_control bit 11 write-only write enable
// - reads anywhere, writes customer registers only
// - writes to reserved areas silently dropped
// - programming time, no lockout by device
// - command byte: region, address, read bit
// - command mode disables analog output
`timescale 1ns/1ps
`include "ascr_regs.svh"
module ascr_cmd_regs
  import ascr_pkg::*;
#(
  parameter int CMD_ENT_CYCLES = `ASCR_TCMD_ENT_US * `ASCR_CLK_MHZ
)(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        txn_valid,
  input  wire logic [7:0]  txn_cmd,
  input  wire logic [15:0] txn_wdata,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  input  wire logic        diag_cond_in,
  input  wire logic        undervoltage_in,
  input  wire logic        field_loss_in,
  input  wire logic        field_loss_detect_en,
  input  wire logic        nvm_readout_strobe,
  input  wire logic        nvm_single_err,
  input  wire logic        nvm_double_err,
  input  wire logic        crc_check_strobe,
  input  wire logic        crc_mismatch,
  output logic             nvm_wr_strobe,
  output logic             nvm_rd_strobe,
  output logic [3:0]       nvm_addr,
  output logic [15:0]      nvm_wdata,
  input  wire logic [15:0] nvm_rd_data,
  output logic             nvm_prog_busy,
  output logic             command_mode,
  output logic             analog_out_enable,
  output logic             pump_clock_enable,
  output logic             nvm_write_enable,
  output logic             diagnostic_suppress,
  output logic             diag_mode_out
);
  localparam int TPROG_CYCLES = `ASCR_TPROG_US * `ASCR_CLK_MHZ;
  // ========================================================
  // command decode
  function automatic logic is_cmd(input logic [7:0] c,
                                  input logic [3:0] a, input logic rd);
    is_cmd = c[7:5] == `ASCR_REGION_CMD && c[4:1] == a && c[0] == rd;
  endfunction : is_cmd

  logic nvm_sel;
  logic cust_sel;
  assign nvm_sel  = txn_valid && txn_cmd[7:5] == `ASCR_REGION_NVM;
  assign cust_sel = txn_cmd[4:1] >= `ASCR_CUST_FIRST;
  // ========================================================
  // pin synchronisers: diag, undervoltage, field loss
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {field_loss_in, undervoltage_in, diag_cond_in};
      sync2_reg <= sync1_reg;
    end
  end
  // ========================================================
  // mode and entry window
  ascr_mode_t mode_reg, mode_next;
  logic [19:0] win_reg, win_next;
  logic key_hit;
  logic diag_active;
  assign key_hit = txn_valid && is_cmd(txn_cmd, `ASCR_ADDR_KEY, 1'b0)
                   && txn_wdata == `ASCR_KEY_VALUE;
  always_comb begin
    mode_next = mode_reg;
    win_next  = win_reg;
    case (mode_reg)
      ASCR_WAIT_KEY: begin
        win_next = win_reg + 20'h1;
        if (key_hit)
          mode_next = ASCR_COMMAND;
        else if (win_reg >= 20'(CMD_ENT_CYCLES - 1))
          mode_next = ASCR_NORMAL;
      end
      // a channel stuck in diagnostics may still take the key
      ASCR_NORMAL: if (key_hit && diag_active) mode_next = ASCR_COMMAND;
      ASCR_COMMAND: mode_next = ASCR_COMMAND;
      default: mode_next = ASCR_WAIT_KEY;
    endcase
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_reg <= ASCR_WAIT_KEY;
      win_reg  <= 20'h0;
    end else begin
      mode_reg <= mode_next;
      win_reg  <= win_next;
    end
  end
  assign command_mode      = mode_reg == ASCR_COMMAND;
  assign analog_out_enable = !command_mode;
  // ========================================================
  // control, test and status bits
  logic cmd_ok, ctrl_wr, test_wr;
  logic supp_reg, supp_next, pump_reg, pump_next, wren_reg, wren_next;
  logic corr_reg, corr_next, unc_reg, unc_next;
  logic floss_reg, floss_next, crc_reg, crc_next;
  logic [15:0] status_word;
  assign cmd_ok  = command_mode && txn_valid;
  assign ctrl_wr = cmd_ok && is_cmd(txn_cmd, `ASCR_ADDR_CTRL, 1'b0);
  assign test_wr = cmd_ok && is_cmd(txn_cmd, `ASCR_ADDR_TEST, 1'b0);
  always_comb begin
    supp_next  = supp_reg;
    pump_next  = pump_reg;
    wren_next  = wren_reg;
    if (ctrl_wr) begin
      supp_next = txn_wdata[`ASCR_BIT_SUPP];
      pump_next = txn_wdata[`ASCR_BIT_PUMP];
    end
    if (test_wr)
      wren_next = txn_wdata[`ASCR_BIT_WREN];
    // sticky flags clear only at power-on reset
    corr_next  = corr_reg || (nvm_readout_strobe && nvm_single_err);
    unc_next   = unc_reg || (nvm_readout_strobe && nvm_double_err);
    floss_next = floss_reg || sync2_reg[2];
    crc_next   = crc_check_strobe ? crc_mismatch : crc_reg;
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      supp_reg  <= 1'(`ASCR_CTRL_RST >> `ASCR_BIT_SUPP);
      pump_reg  <= 1'(`ASCR_CTRL_RST >> `ASCR_BIT_PUMP);
      wren_reg  <= 1'(`ASCR_TEST_RST >> `ASCR_BIT_WREN);
      corr_reg  <= 1'b0;
      unc_reg   <= 1'b0;
      floss_reg <= 1'b0;
      crc_reg   <= 1'b0;
    end else begin
      supp_reg  <= supp_next;
      pump_reg  <= pump_next;
      wren_reg  <= wren_next;
      corr_reg  <= corr_next;
      unc_reg   <= unc_next;
      floss_reg <= floss_next;
      crc_reg   <= crc_next;
    end
  end
  assign diag_active = sync2_reg[0] || unc_reg
                       || (floss_reg && field_loss_detect_en);
  assign diag_mode_out       = diag_active && !supp_reg;
  assign pump_clock_enable   = pump_reg;
  assign nvm_write_enable    = wren_reg;
  assign diagnostic_suppress = supp_reg;
  always_comb begin
    status_word = 16'h0000;
    status_word[`ASCR_BIT_DIAG]   = diag_active;
    status_word[`ASCR_BIT_UV]     = sync2_reg[1];
    status_word[`ASCR_BIT_PUMP]   = pump_reg;
    status_word[`ASCR_BIT_CORR]   = corr_reg;
    status_word[`ASCR_BIT_UNCORR] = unc_reg;
    status_word[`ASCR_BIT_FLOSS]  = floss_reg;
    status_word[`ASCR_BIT_CRC]    = crc_reg;
  end
  // ========================================================
  // memory access and read pipeline
  // writes below 8h and reserved regions fall through untouched
  logic nwr_reg, nwr_next, nrd_reg, nrd_next, rv_reg, rv_next;
  logic stg_reg, stg_next, stg_nvm_reg, stg_nvm_next;
  logic [3:0] addr_reg, addr_next;
  logic [15:0] wd_reg, wd_next, stg_reg_data, stg_data_next, rd_reg, rd_next;
  logic [19:0] prog_reg, prog_next;
  always_comb begin
    nwr_next      = command_mode && nvm_sel && !txn_cmd[0]
                    && cust_sel;
    nrd_next      = command_mode && nvm_sel && txn_cmd[0];
    addr_next     = (nwr_next || nrd_next) ? txn_cmd[4:1] : addr_reg;
    wd_next       = nwr_next ? txn_wdata : wd_reg;
    stg_next      = cmd_ok && txn_cmd[0]
                    && (txn_cmd[7:5] == `ASCR_REGION_CMD
                        || txn_cmd[7:5] == `ASCR_REGION_NVM);
    stg_nvm_next  = nrd_next;
    stg_data_next = is_cmd(txn_cmd, `ASCR_ADDR_CTRL, 1'b1)
                    ? status_word : 16'h0000;
    rv_next       = stg_reg;
    rd_next       = !stg_reg ? rd_reg
                    : stg_nvm_reg ? nvm_rd_data : stg_reg_data;
    // busy is advisory only, nothing is locked out
    prog_next     = nwr_reg ? 20'(TPROG_CYCLES)
                    : (prog_reg != 20'h0 ? prog_reg - 20'h1 : 20'h0);
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      nwr_reg      <= 1'b0;
      nrd_reg      <= 1'b0;
      addr_reg     <= 4'h0;
      wd_reg       <= 16'h0000;
      stg_reg      <= 1'b0;
      stg_nvm_reg  <= 1'b0;
      stg_reg_data <= 16'h0000;
      rv_reg       <= 1'b0;
      rd_reg       <= 16'h0000;
      prog_reg     <= 20'h0;
    end else begin
      nwr_reg      <= nwr_next;
      nrd_reg      <= nrd_next;
      addr_reg     <= addr_next;
      wd_reg       <= wd_next;
      stg_reg      <= stg_next;
      stg_nvm_reg  <= stg_nvm_next;
      stg_reg_data <= stg_data_next;
      rv_reg       <= rv_next;
      rd_reg       <= rd_next;
      prog_reg     <= prog_next;
    end
  end
  assign nvm_wr_strobe = nwr_reg;
  assign nvm_rd_strobe = nrd_reg;
  assign nvm_addr      = addr_reg;
  assign nvm_wdata     = wd_reg;
  assign nvm_prog_busy = prog_reg != 20'h0;
  assign rd_valid      = rv_reg;
  assign rd_data       = rd_reg;
  // ========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_key_entry;
    mode_reg == ASCR_WAIT_KEY && key_hit |=> command_mode;
  endproperty
  a_key_entry: assert property (p_key_entry) else $error("key missed");
  property p_no_late_key;
    mode_reg == ASCR_NORMAL && !diag_active |=> !command_mode;
  endproperty
  a_no_late_key: assert property (p_no_late_key) else $error("late key");
  property p_diag_read;
    cmd_ok && is_cmd(txn_cmd, `ASCR_ADDR_CTRL, 1'b1)
    |=> ##1 rd_valid && rd_data[15] == $past(diag_active, 2)
            && rd_data[12] == $past(sync2_reg[1], 2);
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("status bad");
  property p_supp; supp_reg |-> !diag_mode_out; endproperty
  a_supp: assert property (p_supp) else $error("suppress ignored");
  property p_pump;
    ctrl_wr |=> pump_clock_enable == $past(txn_wdata[11]);
  endproperty
  a_pump: assert property (p_pump) else $error("pump bit");
  property p_sticky; corr_reg && unc_reg |=> corr_reg && unc_reg; endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_unc_set;
    nvm_readout_strobe && nvm_double_err |=> unc_reg && diag_active;
  endproperty
  a_unc_set: assert property (p_unc_set) else $error("uncorr");
  property p_floss; floss_reg |=> floss_reg; endproperty
  a_floss: assert property (p_floss) else $error("floss dropped");
  property p_crc;
    crc_check_strobe |=> crc_reg == $past(crc_mismatch);
  endproperty
  a_crc: assert property (p_crc) else $error("crc flag");
  property p_wren;
    test_wr |=> nvm_write_enable == $past(txn_wdata[11]);
  endproperty
  a_wren: assert property (p_wren) else $error("write enable");
  property p_cust_only;
    nvm_wr_strobe |-> nvm_addr >= `ASCR_CUST_FIRST && command_mode;
  endproperty
  a_cust_only: assert property (p_cust_only) else $error("bad write");
  property p_resv_drop;
    txn_valid && !txn_cmd[0] && txn_cmd[7:5] != `ASCR_REGION_NVM
    && txn_cmd[7:5] != `ASCR_REGION_CMD
    |=> !nvm_wr_strobe && $stable(pump_reg);
  endproperty
  a_resv_drop: assert property (p_resv_drop) else $error("resv write");
  property p_analog; $rose(command_mode) |-> !analog_out_enable; endproperty
  a_analog: assert property (p_analog) else $error("analog on");
  c_entry: cover property (mode_reg == ASCR_WAIT_KEY ##1 command_mode);
  c_nvm_wr: cover property (nvm_wr_strobe ##1 nvm_prog_busy);
  c_nvm_rd: cover property (nvm_rd_strobe ##1 rd_valid);
endmodule : ascr_cmd_regs

// >>> testbench/ascr_master_model.sv
// programming master model presenting decoded link transactions
`timescale 1ns/1ps
module ascr_master_model (
  input  wire logic        clock,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  input  wire logic        nvm_prog_busy,
  output logic             txn_valid,
  output logic [7:0]       txn_cmd,
  output logic [15:0]      txn_wdata
);
  initial begin
    txn_valid = 1'b0;
    txn_cmd   = 8'h00;
    txn_wdata = 16'h0000;
  end
  // ==========================================================
  // transactions
  // released fields show the inverse so stale values never match
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(negedge clock);
    txn_valid <= 1'b1;
    txn_cmd   <= c;
    txn_wdata <= d;
    @(negedge clock);
    txn_valid <= 1'b0;
    txn_cmd   <= ~c;
    txn_wdata <= ~d;
    @(negedge clock);
  endtask : send
  task automatic fetch(input logic [7:0] c, output logic [15:0] d,
                       output bit got);
    d   = 16'h0000;
    got = 1'b0;
    send(c, 16'h0000);
    for (int n = 0; n < 4 && !got; n++) begin
      if (rd_valid === 1'b1) begin
        got = 1'b1;
        d   = rd_data;
      end else begin
        @(negedge clock);
      end
    end
  endtask : fetch
  // no lockout in the device, so the master holds off itself
  task automatic settle(output int n);
    n = 0;
    for (int k = 0; k < 1000; k++) begin
      @(negedge clock);
      if (nvm_prog_busy === 1'b1) n++;
      else if (k > 2) break;
    end
  endtask : settle
  // write enable strictly before the pump clock
  task automatic arm_pump;
    send(8'h96, 16'h0800);
    send(8'h82, 16'h0800);
  endtask : arm_pump
endmodule : ascr_master_model

// >>> testbench/angle_sensor_command_regs_tb.sv
// self-checking bench of the command register set
`timescale 1ns/1ps
`include "ascr_regs.svh"
module angle_sensor_command_regs_tb;
  import ascr_pkg::*;
  localparam int ENT   = 200;
  localparam int TPROG = `ASCR_TPROG_US * `ASCR_CLK_MHZ;
  logic        clock, srst, txn_valid, rd_valid, ok, wr_stb, rd_stb, busy;
  logic        dg_in, uv_in, ls_in, ls_en, ro_stb, s_err, d_err;
  logic        crc_stb, crc_bad, cmd_mode, ana_en, pump_en, wr_en, supp;
  logic        diag_out;
  logic [7:0]  txn_cmd;
  logic [3:0]  nvm_addr;
  logic [15:0] txn_wdata, rd_data, nvm_wdata, nvm_rd_data;
  logic [31:0] rnd;
  logic [15:0] rd_d;
  bit          rd_got;
  logic [15:0] mem [16];
  logic [15:0] exp_mem [16];
  int          bad_count, n_compared, cnt, wr_cnt, rd_cnt, exp_wr;
  always #20 clock = ~clock;
  assign nvm_rd_data = mem[nvm_addr];
  always @(posedge clock) begin
    if (wr_stb === 1'b1) mem[nvm_addr] <= nvm_wdata;
    // strobes stand one cycle, so they are counted where they stand
    if (wr_stb === 1'b1) wr_cnt <= wr_cnt + 1;
    if (rd_stb === 1'b1) rd_cnt <= rd_cnt + 1;
  end
  ascr_master_model m_u (.clock(clock), .rd_valid(rd_valid),
    .rd_data(rd_data), .nvm_prog_busy(busy), .txn_valid(txn_valid),
    .txn_cmd(txn_cmd), .txn_wdata(txn_wdata));
  ascr_cmd_regs #(.CMD_ENT_CYCLES(ENT)) dut_u (.clock(clock), .srst(srst),
    .txn_valid(txn_valid), .txn_cmd(txn_cmd), .txn_wdata(txn_wdata),
    .rd_valid(rd_valid), .rd_data(rd_data), .diag_cond_in(dg_in),
    .undervoltage_in(uv_in), .field_loss_in(ls_in),
    .field_loss_detect_en(ls_en), .nvm_readout_strobe(ro_stb),
    .nvm_single_err(s_err), .nvm_double_err(d_err),
    .crc_check_strobe(crc_stb), .crc_mismatch(crc_bad),
    .nvm_wr_strobe(wr_stb), .nvm_rd_strobe(rd_stb), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .nvm_rd_data(nvm_rd_data),
    .nvm_prog_busy(busy), .command_mode(cmd_mode),
    .analog_out_enable(ana_en), .pump_clock_enable(pump_en),
    .nvm_write_enable(wr_en), .diagnostic_suppress(supp),
    .diag_mode_out(diag_out));
  // ==========================================================
  // expectations and checks
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  // f is the field loss flag already gated by its detect enable
  function automatic logic [15:0] status_word(input logic g, input logic u,
      input logic c, input logic e, input logic f, input logic k);
    return {g | e | f, 2'h0, u, 1'b0, 2'h0, c, e, f, 1'b0, k, 4'h0};
  endfunction : status_word
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic rd_chk(input string what, input logic [7:0] c,
                        input logic [15:0] e);
    logic [15:0] d;
    bit          got;
    m_u.fetch(c, d, got);
    chk(what, e, got ? d : ~e);
  endtask : rd_chk
  task automatic summarize;
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // main sequence
  initial begin
    clock = 1'b0;
    srst  = 1'b1;
    {dg_in, uv_in, ls_in, ls_en, ro_stb, s_err, d_err, crc_stb} = 8'h00;
    crc_bad = 1'b0;
    rnd = 32'h00018345;
    for (int i = 0; i < 16; i++) begin
      mem[i]     = 16'ha5a0 + 16'(i);
      exp_mem[i] = mem[i];
    end
    repeat (10) @(negedge clock);
    srst = 1'b0;
    m_u.fetch(8'h83, rd_d, rd_got);
    chk("early read", 16'h0000, {15'h0000, rd_got});
    chk("analog", 16'h0001, {15'h0000, ana_en});
    m_u.send(8'h94, 16'h16f5);
    chk("bad key", 16'h0000, {15'h0000, cmd_mode});
    m_u.send(8'h94, `ASCR_KEY_VALUE);
    chk("entry", 16'h0001, {15'h0000, cmd_mode});
    chk("analog off", 16'h0000, {15'h0000, ana_en});
    // pump bit left clear: it may only follow the write enable; the device takes it without checking write enable
    m_u.send(8'h82, 16'hf7ff);
    rd_chk("ctrl mask", 8'h83, 16'h0000);
    m_u.send(8'h82, 16'h0000);
    {dg_in, uv_in} = 2'b11;
    repeat (3) @(negedge clock);
    chk("diag out", 16'h0001, {15'h0000, diag_out});
    rd_chk("status", 8'h83, status_word(1, 1, 0, 0, 0, 0));
    m_u.send(8'h82, 16'h4000);
    chk("suppress", 16'h0001, {15'h0000, supp});
    chk("diag off", 16'h0000, {15'h0000, diag_out});
    rd_chk("status sup", 8'h83, status_word(1, 1, 0, 0, 0, 0));
    {dg_in, uv_in} = 2'b00;
    m_u.send(8'h82, 16'h0000);
    {ro_stb, s_err, d_err, ls_in, ls_en, crc_stb, crc_bad} = 7'h7f;
    @(negedge clock);
    {ro_stb, s_err, d_err, crc_stb, crc_bad} = 5'h00;
    repeat (3) @(negedge clock);
    // causes gone, flags must hold until power-on reset
    {ro_stb, ls_in} = 2'b10;
    @(negedge clock);
    ro_stb = 1'b0;
    repeat (3) @(negedge clock);
    rd_chk("sticky", 8'h83, status_word(0, 0, 1, 1, 1, 1));
    chk("diag err", 16'h0001, {15'h0000, diag_out});
    crc_stb = 1'b1;
    @(negedge clock);
    crc_stb = 1'b0;
    rd_chk("crc redo", 8'h83, status_word(0, 0, 1, 1, 1, 0));
    m_u.arm_pump();
    chk("wr enable", 16'h0001, {15'h0000, wr_en});
    chk("pump", 16'h0001, {15'h0000, pump_en});
    rd_chk("pump rd", 8'h83, status_word(0, 0, 1, 1, 1, 0) | 16'h0800);
    rd_chk("test read", 8'h97, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr_step(rnd);
      m_u.send({3'h0, i[3:0], 1'b0}, rnd[15:0]);
      exp_wr += int'(i >= 8);
      chk("wr strobe", 16'(exp_wr), 16'(wr_cnt));
      if (i >= 8) begin
        chk("wr addr", {12'h000, i[3:0]}, {12'h000, nvm_addr});
        chk("wr data", rnd[15:0], nvm_wdata);
        exp_mem[i] = rnd[15:0];
        m_u.settle(cnt);
        ok = cnt >= TPROG - 1 && cnt <= TPROG + 1;
        chk("prog", 16'h0001, {15'h0000, ok});
      end
    end
    for (int r = 1; r < 8; r++) begin
      if (r != 4) begin
        m_u.send({r[2:0], 4'h8, 1'b0}, 16'h1234);
        chk("region drop", 16'(exp_wr), 16'(wr_cnt));
      end
    end
    for (int i = 0; i < 16; i++) begin
      rd_chk("nvm read", {3'h0, i[3:0], 1'b1}, exp_mem[i]);
    end
    chk("rd strobes", 16'h0010, 16'(rd_cnt));
    srst = 1'b1;
    repeat (10) @(negedge clock);
    srst = 1'b0;
    chk("pump rst", 16'h0000, {15'h0000, pump_en});
    chk("wren rst", 16'h0000, {15'h0000, wr_en});
    chk("supp rst", 16'h0000, {15'h0000, supp});
    repeat (ENT + 20) @(negedge clock);
    m_u.send(8'h94, `ASCR_KEY_VALUE);
    chk("late key", 16'h0000, {15'h0000, cmd_mode});
    summarize();
  end
endmodule : angle_sensor_command_regs_tb
